// *** smd_pkg.sv ***
// Package of constants for the stepper driver control register block.
package smd_pkg;

  // ****************************************************************
  // Frame and address layout
  // ****************************************************************
  localparam int          WORD_W      = 16;
  localparam int          ADDR_HI     = 15;
  localparam int          ADDR_LO     = 14;
  localparam logic [1:0]  ADDR_CFG0   = 2'h0;
  localparam logic [1:0]  ADDR_CFG1   = 2'h1;
  localparam logic [1:0]  ADDR_RUN    = 2'h2;
  localparam logic [1:0]  ADDR_TBL    = 2'h3;

  // ****************************************************************
  // Second configuration word fields and reset
  // ****************************************************************
  localparam int          C1_OSC      = 13;
  localparam int          C1_TSC_LO   = 11;
  localparam int          C1_CD_LO    = 2;
  localparam int          C1_PIN_SELECT_A_LO  = 0;
  localparam logic [15:0] C1_RESET    = 16'h5020;

  // ****************************************************************
  // Zeroth configuration word fields used here, and reset
  // ****************************************************************
  localparam int          C0_PWM      = 0;
  localparam int          C0_TOF_LO   = 1;
  localparam logic [15:0] C0_RESET    = 16'h2712;

  // ****************************************************************
  // Run word fields and reset
  // ****************************************************************
  localparam int          RN_EN       = 13;
  localparam int          RN_OL_LO    = 11;
  localparam int          RN_HLR      = 10;
  localparam int          RN_SLEW     = 9;
  localparam int          RN_BRK      = 8;
  localparam int          RN_DCY_LO   = 6;
  localparam int          RN_SC_LO    = 0;
  localparam logic [15:0] RN_RESET    = 16'h8A80;

  // ****************************************************************
  // Table load and fault word layout
  // ****************************************************************
  localparam int          TB_PAR      = 6;
  localparam int          TBL_N       = 16;
  localparam int          FW_ANY      = 15;
  localparam int          FW_TW_LO    = 13;
  localparam int          FW_UV       = 11;
  localparam int          FW_ST       = 10;
  localparam int          FW_OLB      = 9;
  localparam int          FW_OLA      = 8;
  localparam logic [15:0] FAULT_POR   = 16'hFFFF;

  // ****************************************************************
  // Timing, in nanoseconds, scaled to a 4 ns (250 MHz) clock
  // ****************************************************************
  localparam int          CLK_NS      = 4;
  localparam int          TOF_BASE_NS = 20000;
  localparam int          TOF_STEP_NS = 4000;
  localparam int          TSC_HALF_NS = 500;

  typedef enum logic [2:0] {
    SMD_IDLE = 3'b001,
    SMD_SHIFT = 3'b010,
    SMD_DONE = 3'b100
  } smd_state_e;

  function automatic int smd_cyc(input int ns);
    smd_cyc = (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
  endfunction : smd_cyc

endpackage : smd_pkg

// *** smd_sync.sv ***
// Two-flop synchroniser bank for pins from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module smd_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,     // System clock.
  input  wire logic         sys_rst, // Synchronous reset.
  input  wire logic [W-1:0] d,       // Asynchronous inputs.
  output logic      [W-1:0] q        // Synchronised outputs.
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Reset to the idle pin levels so no false edge follows reset.
      s1_r <= RST;
      s2_r <= RST;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule : smd_sync
`default_nettype wire

// *** smd_timer.sv ***
// Down counter that pulses done after a loaded number of cycles.
`timescale 1ns/1ps
`default_nettype none
module smd_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,     // System clock.
  input  wire logic         sys_rst, // Synchronous reset.
  input  wire logic         start,   // Load and run.
  input  wire logic [W-1:0] cycles,  // Length in cycles.
  output logic              done     // One-cycle pulse at expiry.
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         run_r;
  logic         run_nxt;
  logic         done_nxt;
  always_comb begin
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    done_nxt = 1'b0;
    if (start) begin
      cnt_nxt = cycles;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r <= W'(1)) begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - W'(1);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      done  <= done_nxt;
    end
  end
endmodule : smd_timer
`default_nettype wire

// *** smd_regs.sv ***
// Serial register bank of a microstepping stepper driver.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// [RULE_01] Fixed off-time: code picks 20..48 us.
// [RULE_02] Fixed frequency: code picks listed chop period.
// [RULE_03] Clock source bit picks internal or external.
// [RULE_04] Short fault flagged after programmed detect delay.
// [RULE_05] Four-bit count delta sets stall threshold.
// [RULE_06] Two-bit select routes diagnostic pin source.
// [RULE_07] Bridges on when enable bit or pin.
// [RULE_08] Open-load threshold 20 to 50 percent.
// [RULE_09] Recirculation bit selects high or low side.
// [RULE_10] Slew bit enables slew; brake bit brakes.
// [RULE_11] Two-bit field selects current decay mode.
// [RULE_12] Signed step delta adjusts step angle.
// [RULE_13] Table word: six value bits, odd parity.
// [RULE_14] Each table value fills eight angle positions; code fills four per value (the last entry only two).
// [RULE_15] First fault word upper byte layout.
// [RULE_16] First fault word low byte: switch shorts.
// [RULE_17] Second fault word returns step angle.
// [RULE_18] Thermal code: none, cold, hot, shutdown.
// [RULE_19] Undervoltage from regulator or motor supply.
// [RULE_20] Controller keeps step pulses clear of strobe.
// [RULE_21] Table index runs 0..15, then ignores.
// [RULE_22] Parity error sets fault, value still stored.
// [RULE_23] Top flag is OR of all faults.
// [RULE_24] Sixteen bits, MSB first, two address bits.
module smd_regs
  import smd_pkg::*;
#(
  parameter int TMR_W = 16
) (
  input  wire logic       clk,               // 250 MHz system clock.
  input  wire logic       sys_rst,           // Synchronous reset.
  input  wire logic       serial_strobe_n,   // Frame strobe, low active.
  input  wire logic       sck,               // Serial clock pin.
  input  wire logic       sdi,               // Serial data in.
  output logic            sdo,               // Serial data out.
  output logic            sdo_oe,            // High while sdo driven.
  input  wire logic       enable_pin,        // External enable pin.
  input  wire logic       ext_clk_pin,       // External timing clock.
  input  wire logic       regulator_supply_uv, // Regulator supply low.
  input  wire logic       motor_supply_uv,   // Motor supply low.
  input  wire logic [1:0] thermal_code,      // Thermal monitor code.
  input  wire logic       stall_flag,        // Stall detector.
  input  wire logic       open_load_phase_a, // Phase A open load.
  input  wire logic       open_load_phase_b, // Phase B open load.
  input  wire logic [7:0] short_raw,         // Raw switch overcurrent.
  input  wire logic       pwm_on_a,          // Phase A PWM on.
  output logic            bridge_enable,     // Output bridges on.
  output logic            pin_select_a,      // Diagnostic pin level.
  output logic            use_ext_clk,       // Timing clock source.
  output logic            fixed_freq,        // Chop mode.
  output logic [15:0]     chop_cycles,       // Off time or period.
  output logic [3:0]      stall_count_delta, // Stall threshold.
  output logic [1:0]      open_load_threshold, // Open-load code.
  output logic            recirc_side_select, // Low side when high.
  output logic            slew_enable,       // Slew control on.
  output logic            brake_bit,         // Brake active.
  output logic [1:0]      decay_mode_select, // Decay mode.
  output logic [5:0]      step_angle,        // Step angle number.
  output logic [5:0]      cur_a,             // Phase A table value.
  output logic [5:0]      cur_b              // Phase B table value.
);
  import smd_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [15:0] pin_s;
  smd_sync #(.W(16), .RST(16'hC000)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({serial_strobe_n, sck, sdi, enable_pin, ext_clk_pin,
               regulator_supply_uv, motor_supply_uv, thermal_code,
               stall_flag, open_load_phase_a, open_load_phase_b,
               pwm_on_a, 3'h0}),
    .q       (pin_s)
  );
  logic stb_n_s, sck_s, sdi_s, en_s, uv_any;
  assign stb_n_s = pin_s[15];
  assign sck_s   = pin_s[14];
  assign sdi_s   = pin_s[13];
  assign en_s    = pin_s[12];
  // [RULE_19] Either supply low.
  assign uv_any  = pin_s[10] | pin_s[9];
  logic [15:0] cfg0_r, cfg1_r, run_r;

  // ****************************************************************
  // Serial frame engine
  // ****************************************************************
  smd_state_e  st_r, st_nxt;
  logic [15:0] sh_r, sh_nxt, out_r, out_nxt;
  logic [4:0]  bits_r, bits_nxt;
  logic        sck_d_r, rise, fall;
  logic        wr_stb, frame_err;
  logic [15:0] word;
  assign rise = sck_s & ~sck_d_r;
  assign fall = ~sck_s & sck_d_r;
  assign word = sh_r;

  logic [15:0] fault_flags_overcurrent, fault_flags_angle_readback;
  always_comb begin
    st_nxt    = st_r;
    sh_nxt    = sh_r;
    out_nxt   = out_r;
    bits_nxt  = bits_r;
    wr_stb    = 1'b0;
    frame_err = 1'b0;
    case (st_r)
      SMD_IDLE: begin
        if (!stb_n_s) begin
          st_nxt   = SMD_SHIFT;
          bits_nxt = '0;
          out_nxt  = fault_flags_overcurrent;
        end
      end
      SMD_SHIFT: begin
        // [RULE_24] MSB first capture.
        if (rise && bits_r < 5'(WORD_W)) begin
          sh_nxt   = {sh_r[14:0], sdi_s};
          bits_nxt = bits_r + 5'h1;
          if (bits_r == 5'h1 && sh_r[0] == 1'b0 && sdi_s)
            out_nxt = {fault_flags_angle_readback[13:0], 2'b00};
          else
            out_nxt = {out_r[14:0], 1'b0};
        end
        if (stb_n_s) begin
          st_nxt = SMD_IDLE;
          if (bits_r == 5'(WORD_W))
            wr_stb = 1'b1;
          else if (bits_r != 5'h0)
            frame_err = 1'b1;
        end
      end
      default: st_nxt = SMD_IDLE;
    endcase
  end
  assign sdo    = out_r[15];
  assign sdo_oe = (st_r == SMD_SHIFT);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r    <= SMD_IDLE;
      sh_r    <= '0;
      out_r   <= '0;
      bits_r  <= '0;
      sck_d_r <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      sh_r    <= sh_nxt;
      out_r   <= out_nxt;
      bits_r  <= bits_nxt;
      sck_d_r <= sck_s;
    end
  end

  // ****************************************************************
  // Writable registers and table loader
  // ****************************************************************
  logic [15:0] cfg1_nxt, run_nxt;
  logic [5:0]  sa_r, sa_nxt;
  logic [4:0]  idx_r, idx_nxt;
  logic [5:0]  tbl_r [TBL_N];
  logic        tbl_we, par_err;
  logic [1:0]  addr;
  assign addr   = word[ADDR_HI:ADDR_LO];
  assign cfg0_r = C0_RESET;

  always_comb begin
    cfg1_nxt = cfg1_r;
    run_nxt  = run_r;
    sa_nxt   = sa_r;
    idx_nxt  = idx_r;
    tbl_we   = 1'b0;
    par_err  = 1'b0;
    if (frame_err) begin
      idx_nxt = '0;
    end else if (wr_stb) begin
      case (addr)
        ADDR_CFG1: begin
          cfg1_nxt = word;
          idx_nxt  = '0;
        end
        ADDR_RUN: begin
          run_nxt = word;
          idx_nxt = '0;
          // [RULE_12] Signed delta wraps modulo 64.
          sa_nxt  = sa_r + word[RN_SC_LO +: 6];
        end
        ADDR_TBL: begin
          // [RULE_21] Sixteen loads then ignore.
          if (idx_r < 5'(TBL_N)) begin
            tbl_we  = 1'b1;
            idx_nxt = idx_r + 5'h1;
            // [RULE_13] [RULE_22] Odd parity check.
            par_err = ~(^word[TB_PAR:0]);
          end
        end
        default: idx_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg1_r <= C1_RESET;
      run_r  <= RN_RESET;
      sa_r   <= '0;
      idx_r  <= '0;
    end else begin
      cfg1_r <= cfg1_nxt;
      run_r  <= run_nxt;
      sa_r   <= sa_nxt;
      idx_r  <= idx_nxt;
    end
  end

  // The table survives reset; contents are undefined until loaded.
  always_ff @(posedge clk) begin
    if (tbl_we)
      tbl_r[idx_r[3:0]] <= word[5:0];
  end

  // ****************************************************************
  // Table expansion to phase currents
  // ****************************************************************
  function automatic logic [5:0] quad_val(input logic [5:0] a);
    logic [4:0] m;
    m = a[4:0];
    // [RULE_14] Mirror about 16; 0 and 32 hold zero.
    if (m == 5'h0)
      quad_val = 6'h0;
    else if (m <= 5'h10)
      quad_val = tbl_r[4'(m - 5'h1)];
    else
      quad_val = tbl_r[4'(5'h1F - m)];
  endfunction : quad_val

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_a <= '0;
      cur_b <= '0;
    end else begin
      cur_a <= quad_val(sa_r);
      cur_b <= quad_val(sa_r + 6'h10);
    end
  end
  assign step_angle = sa_r;

  // ****************************************************************
  // Fault capture and readback words
  // ****************************************************************
  logic [7:0]  short_r;
  logic        err_r, stall_s;
  logic        tsc_start, tsc_done;
  logic [TMR_W-1:0] tsc_cyc;
  assign stall_s = pin_s[6];
  // [RULE_04] Detect delay 0.5,1,2,3 us.
  always_comb begin
    case (cfg1_r[C1_TSC_LO +: 2])
      2'h0:    tsc_cyc = TMR_W'(smd_cyc(TSC_HALF_NS));
      2'h1:    tsc_cyc = TMR_W'(smd_cyc(2 * TSC_HALF_NS));
      2'h2:    tsc_cyc = TMR_W'(smd_cyc(4 * TSC_HALF_NS));
      default: tsc_cyc = TMR_W'(smd_cyc(6 * TSC_HALF_NS));
    endcase
  end
  logic tsc_busy_r;
  assign tsc_start = (|short_raw) & ~tsc_busy_r;
  smd_timer #(.W(TMR_W)) u_tsc (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (tsc_start),
    .cycles  (tsc_cyc),
    .done    (tsc_done)
  );

  logic clr_faults;
  assign clr_faults = wr_stb | frame_err;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      short_r    <= '0;
      err_r      <= 1'b1;
      tsc_busy_r <= 1'b0;
    end else begin
      tsc_busy_r <= (tsc_busy_r | tsc_start) & ~tsc_done;
      // Set wins over the end-of-access clear.
      // [RULE_16] Switch flags after delay.
      short_r <= (clr_faults ? 8'h0 : short_r)
                 | (tsc_done ? short_raw : 8'h0);
      err_r   <= (clr_faults ? 1'b0 : err_r) | par_err | frame_err;
    end
  end

  // [RULE_15] [RULE_18] Upper byte of both words.
  logic [6:0] upper;
  assign upper = {pin_s[8:7], 1'b0, uv_any, stall_s, pin_s[4], pin_s[5]};
  // [RULE_23] Top flag covers all faults.
  logic any_fault_flag;
  assign any_fault_flag = (|upper) | (|short_r) | err_r;
  assign fault_flags_overcurrent = {any_fault_flag, upper, short_r};
  // [RULE_17] Zeros then step angle.
  assign fault_flags_angle_readback = {any_fault_flag, upper, 2'b00, sa_r};

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  // [RULE_07] Enable bit OR pin.
  assign bridge_enable = run_r[RN_EN] | en_s;
  // [RULE_06] Diagnostic pin routing.
  always_comb begin
    case (cfg1_r[C1_PIN_SELECT_A_LO +: 2])
      2'h0:    pin_select_a = ~any_fault_flag;
      2'h1:    pin_select_a = ~stall_s;
      2'h2:    pin_select_a = pin_s[3];
      default: pin_select_a = |pin_s[8:7];
    endcase
  end
  // [RULE_01] [RULE_02] Chop timing by mode.
  assign fixed_freq = cfg0_r[C0_PWM];
  always_comb begin
    logic [2:0] c;
    c = cfg0_r[C0_TOF_LO +: 3];
    if (!fixed_freq)
      chop_cycles = 16'(smd_cyc(TOF_BASE_NS + TOF_STEP_NS * int'(c)));
    else
      case (c)
        3'h0:    chop_cycles = 16'(smd_cyc(24000));
        3'h1:    chop_cycles = 16'(smd_cyc(32000));
        3'h2:    chop_cycles = 16'(smd_cyc(40000));
        3'h3:    chop_cycles = 16'(smd_cyc(46000));
        3'h4:    chop_cycles = 16'(smd_cyc(52000));
        3'h5:    chop_cycles = 16'(smd_cyc(56000));
        3'h6:    chop_cycles = 16'(smd_cyc(60000));
        default: chop_cycles = 16'(smd_cyc(64000));
      endcase
  end
  // [RULE_03] Clock source select.
  // The external clock is only steered on; the timers above use clk.
  assign use_ext_clk         = cfg1_r[C1_OSC];
  // [RULE_05] Stall count delta.
  assign stall_count_delta   = cfg1_r[C1_CD_LO +: 4];
  // [RULE_08] [RULE_09] [RULE_10] [RULE_11] Run fields.
  assign open_load_threshold = run_r[RN_OL_LO +: 2];
  assign recirc_side_select  = run_r[RN_HLR];
  assign slew_enable         = run_r[RN_SLEW];
  assign brake_bit           = run_r[RN_BRK];
  assign decay_mode_select   = run_r[RN_DCY_LO +: 2];

endmodule : smd_regs
`default_nettype wire

// *** smd_regs_props.sv ***
// Port assertions for the stepper driver register block.
`timescale 1ns/1ps
`default_nettype none
module smd_regs_props (
  input wire logic        clk,               // Clock.
  input wire logic        sys_rst,           // Reset.
  input wire logic        serial_strobe_n,   // Frame strobe.
  input wire logic        sdo_oe,            // Output enable.
  input wire logic        enable_pin,        // Enable pin.
  input wire logic        bridge_enable,     // Bridges on.
  input wire logic        fixed_freq,        // Chop mode.
  input wire logic [15:0] chop_cycles,       // Chop length.
  input wire logic        use_ext_clk,       // Clock source.
  input wire logic [3:0]  stall_count_delta, // Stall delta.
  input wire logic        slew_enable,       // Slew on.
  input wire logic [1:0]  decay_mode_select, // Decay mode.
  input wire logic [5:0]  step_angle,        // Step angle.
  input wire logic [5:0]  cur_a,             // Phase A value.
  input wire logic [5:0]  cur_b              // Phase B value.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Word zero cannot be written, so the 24 us off time always holds.
  property p_chop; !fixed_freq && chop_cycles == 16'h1770; endproperty
  a_chop: assert property (p_chop)
    else $error("chop setting differs from default");
  property p_rst_cfg;
    $fell(sys_rst) |-> !use_ext_clk && stall_count_delta == 4'h8;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg)
    else $error("config fields wrong after reset");
  property p_rst_run;
    $fell(sys_rst) |-> slew_enable && decay_mode_select == 2'h2
      && step_angle == 6'h00;
  endproperty
  a_rst_run: assert property (p_rst_run)
    else $error("run fields wrong after reset");
  property p_bridge; enable_pin [*4] |=> bridge_enable; endproperty
  a_bridge: assert property (p_bridge)
    else $error("bridges off while enable pin high");
  property p_oe_on; !serial_strobe_n [*5] |-> sdo_oe; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("serial output not driven in frame");
  property p_oe_off; serial_strobe_n [*8] |-> !sdo_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("serial output driven outside frame");
  // Fields may only move just after a frame closes.
  property p_hold;
    serial_strobe_n [*8] |->
      $stable({use_ext_clk, stall_count_delta, step_angle});
  endproperty
  a_hold: assert property (p_hold)
    else $error("register changed without a frame");
  property p_zero_a;
    (step_angle == 6'h00 || step_angle == 6'h20) [*3] |-> cur_a == 6'h00;
  endproperty
  a_zero_a: assert property (p_zero_a)
    else $error("phase A not zero at its zero angle");
  property p_zero_b;
    (step_angle == 6'h10 || step_angle == 6'h30) [*3] |-> cur_b == 6'h00;
  endproperty
  a_zero_b: assert property (p_zero_b)
    else $error("phase B not zero at its zero angle");
  c_frame: cover property (!serial_strobe_n ##1 serial_strobe_n);
  c_zero: cover property (step_angle == 6'h30 && cur_b == 6'h00);
  c_bridge: cover property ($rose(bridge_enable));
endmodule : smd_regs_props
`default_nettype wire

// *** smd_host.sv ***
// Serial controller model that frames words toward the register block.
`timescale 1ns/1ps
`default_nettype none
module smd_host (
  output logic     serial_strobe_n, // Frame strobe.
  output logic     sck,             // Serial clock, idles high.
  output logic     sdi,             // Serial data.
  input wire logic sdo              // Fault readback.
);
  initial begin
    serial_strobe_n = 1'b1;
    sck = 1'b1;
    sdi = 1'b0;
  end
  // No step pulses driven, so none can meet the strobe.
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] rd);
    rd = 16'h0000;
    serial_strobe_n = 1'b0;
    #32;
    for (int i = 15; i > 15 - n; i--) begin
      sck = 1'b0;
      sdi = w[i];
      #32;
      rd = {rd[14:0], sdo};
      sck = 1'b1;
      #32;
    end
    serial_strobe_n = 1'b1;
    // Released data line flips so a stale bit is never mistaken as held.
    sdi = ~sdi;
    #64;
  endtask : xfer
endmodule : smd_host
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the stepper driver register block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import smd_pkg::*;
  typedef struct packed {
    logic [15:0] w;
    logic [5:0]  ang;
  } smd_row_s;
  logic clk, sys_rst, serial_strobe_n, sck, sdi, sdo, sdo_oe, enable_pin;
  logic ext_clk_pin, regulator_supply_uv, motor_supply_uv, stall_flag;
  logic open_load_phase_a, open_load_phase_b, pwm_on_a, bridge_enable;
  logic pin_select_a, use_ext_clk, fixed_freq, recirc_side_select;
  logic slew_enable, brake_bit;
  logic [1:0] thermal_code, open_load_threshold, decay_mode_select;
  logic [3:0] stall_count_delta;
  logic [7:0] short_raw;
  logic [14:0] fin;
  logic [5:0] step_angle, cur_a, cur_b, ang_m, v;
  logic [15:0] chop_cycles, rd, c1_m, rn_m;
  logic [5:0] tbl [16];
  smd_row_s rows [8];
  int failures, n_tests;
  assign {regulator_supply_uv, motor_supply_uv, thermal_code, stall_flag,
          open_load_phase_a, open_load_phase_b, short_raw} = fin;
  smd_regs i_smd_regs (
    .clk, .sys_rst, .serial_strobe_n, .sck, .sdi, .sdo, .sdo_oe,
    .enable_pin, .ext_clk_pin, .regulator_supply_uv, .motor_supply_uv,
    .thermal_code, .stall_flag, .open_load_phase_a, .open_load_phase_b,
    .short_raw, .pwm_on_a, .bridge_enable, .pin_select_a, .use_ext_clk,
    .fixed_freq, .chop_cycles, .stall_count_delta, .open_load_threshold,
    .recirc_side_select, .slew_enable, .brake_bit, .decay_mode_select,
    .step_angle, .cur_a, .cur_b
  );
  smd_host i_smd_host (.serial_strobe_n, .sck, .sdi, .sdo);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    ext_clk_pin = 1'b0;
    #7;
    forever #32 ext_clk_pin = ~ext_clk_pin;
  end
  initial begin
    #200000;
    failures++;
    summarize();
  end
  task automatic chk(input string s, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic chkf();
    chk("fields", {3'b000, c1_m[C1_OSC], c1_m[C1_CD_LO +: 4],
        rn_m[RN_OL_LO +: 2], rn_m[RN_HLR], rn_m[RN_SLEW], rn_m[RN_BRK],
        rn_m[RN_DCY_LO +: 2], rn_m[RN_EN] | enable_pin},
        {3'b000, use_ext_clk, stall_count_delta, open_load_threshold,
        recirc_side_select, slew_enable, brake_bit, decay_mode_select,
        bridge_enable});
  endtask : chkf
  task automatic wr(input logic [15:0] w, input int n = 16);
    i_smd_host.xfer(w, n, rd);
    if (n == 16 && w[ADDR_HI:ADDR_LO] == ADDR_CFG1) c1_m = w;
    if (n == 16 && w[ADDR_HI:ADDR_LO] == ADDR_RUN) begin
      rn_m = w;
      ang_m = ang_m + w[5:0];
    end
    repeat (2) @(posedge clk);
    #1;
  endtask : wr
  // Switch and error flags are sticky, so a flush frame with quiet inputs comes first.
  task automatic fcase(input logic [14:0] f, input logic [15:0] e);
    fin = 15'h0000;
    repeat (10) @(posedge clk);
    #1;
    wr(16'h0000);
    fin = f;
    repeat (600) @(posedge clk);
    #1;
    wr(16'h0000);
    chk("fault_word", e, rd);
  endtask : fcase
  task automatic do_rst();
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    c1_m = C1_RESET;
    rn_m = RN_RESET;
    ang_m = 6'h00;
    repeat (4) @(posedge clk);
    #1;
    chkf();
    chk("angle", 16'(ang_m), 16'(step_angle));
    wr(16'h0000);
    chk("reset_flag", 16'h0001, 16'(rd[15]));
  endtask : do_rst
  function automatic logic [5:0] amp(input logic [5:0] a);
    if (a[4:0] == 5'h00) return 6'h00;
    if (a[4:0] <= 5'h10) return tbl[a[4:0] - 5'h01];
    return tbl[5'h1F - a[4:0]];
  endfunction : amp
  task automatic summarize();
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    failures = 0;
    n_tests = 0;
    fin = 15'h0000;
    enable_pin = 1'b0;
    pwm_on_a = 1'b0;
    rows = '{'{16'h7FFF, 6'h00}, '{16'h4000, 6'h00}, '{16'h4824, 6'h00},
             '{16'hBF45, 6'h05}, '{16'h807F, 6'h04}, '{16'h889F, 6'h23},
             '{16'h90E0, 6'h03}, '{16'h983C, 6'h3F}};
    do_rst();
    foreach (rows[i]) begin
      wr(rows[i].w);
      chkf();
      chk("angle", 16'(rows[i].ang), 16'(step_angle));
    end
    fcase(15'h4000, 16'h8800);
    fcase(15'h2800, 16'hA800);
    fcase(15'h1600, 16'hC500);
    fcase(15'h1981, 16'hE281);
    fcase(15'h0000, 16'h0000);
    wr(16'h5022);
    for (int b = 0; b < 2; b++) begin
      pwm_on_a = b[0];
      repeat (5) @(posedge clk);
      #1;
      chk("pin_select_a_pin", 16'(b), 16'(pin_select_a));
    end
    // The sixth word carries bad parity and is still stored.
    for (int k = 0; k < 17; k++) begin
      v = (k < 16) ? 6'(k * 4 + 3) : 6'h00;
      wr({2'b11, 7'h00, (~^v) ^ (k == 5), v});
      chk("parity_flag", 16'(k == 6), 16'(rd[15]));
      if (k < 16) tbl[k] = v;
    end
    wr(16'hC015, 8);
    wr(16'hC015);
    chk("error_flag", 16'h0001, 16'(rd[15]));
    tbl[0] = 6'h15;
    for (int n = 0; n < 64; n++) begin
      wr(16'h8A81);
      chk("angle", 16'(ang_m), 16'(step_angle));
      chk("cur_a", 16'(amp(ang_m)), 16'(cur_a));
      chk("cur_b", 16'(amp(ang_m + 6'h10)), 16'(cur_b));
    end
    do_rst();
    enable_pin = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chkf();
    summarize();
  end
endmodule : tb
bind smd_regs smd_regs_props i_smd_regs_props (
  .clk, .sys_rst, .serial_strobe_n, .sdo_oe, .enable_pin, .bridge_enable,
  .fixed_freq, .chop_cycles, .use_ext_clk, .stall_count_delta,
  .slew_enable, .decay_mode_select, .step_angle, .cur_a, .cur_b
);
`default_nettype wire
